// [shared/spz_regs.svh]
// register indices, field positions, reset values and rate divisors
`ifndef SPZ_REGS_SVH
`define SPZ_REGS_SVH

// register indices; byte address is four times the index
`define SPZ_IDX_SER_CTRL 10'h098
`define SPZ_IDX_SER_BUF 10'h099
`define SPZ_IDX_PWR_CTRL 10'h087
`define SPZ_IDX_IRQ_STAT 10'h0a0
`define SPZ_IDX_IRQ_MASK 10'h0a1
`define SPZ_IDX_RATE 10'h0a2

// serial_control fields
`define SPZ_SC_MODE_HI 7
`define SPZ_SC_MODE_LO 6
`define SPZ_SC_MP_EN 5
`define SPZ_SC_RX_EN 4
`define SPZ_SC_TX9 3
`define SPZ_SC_RX9 2
`define SPZ_SC_TX_DONE 1
`define SPZ_SC_RX_DONE 0

// power_control_reg fields
`define SPZ_PC_BAUD_DBL 7
`define SPZ_PC_FE_SEL 6

// interrupt status / mask fields
`define SPZ_IRQ_TX 0
`define SPZ_IRQ_RX 1
`define SPZ_IRQ_FE 2

// reset values
`define SPZ_RST_SER_CTRL 8'h00
`define SPZ_RST_PWR_CTRL 8'h00
`define SPZ_RST_RATE 8'h00
`define SPZ_RST_IRQ 3'h0

// clocks per bit
`define SPZ_M0_SLOW_DIV 16'h000c
`define SPZ_M0_FAST_DIV 16'h0004
`define SPZ_M2_SLOW_DIV 16'h0040
`define SPZ_M2_FAST_DIV 16'h0020
`define SPZ_OVS_NORM 16'h0010
`define SPZ_OVS_DBL 16'h0008

// axi responses
`define SPZ_RESP_OKAY 2'h0
`define SPZ_RESP_SLVERR 2'h2

`endif

// [shared/spz_pkg.sv]
// types shared by the serial port zero block
package spz_pkg;

  typedef enum logic [0:0] {
    SPZ_TX_IDLE = 1'b0,
    SPZ_TX_RUN = 1'b1
  } spz_txst_t;

  typedef enum logic [1:0] {
    SPZ_RX_IDLE = 2'b00,
    SPZ_RX_START = 2'b01,
    SPZ_RX_DATA = 2'b10,
    SPZ_RX_SYNC = 2'b11
  } spz_rxst_t;

  typedef struct packed {
    logic aw_v;
    logic [11:0] aw_addr;
    logic w_v;
    logic [7:0] w_data;
    logic w_lane0;
    logic b_v;
    logic [1:0] b_resp;
    logic r_v;
    logic [31:0] r_data;
    logic [1:0] r_resp;
    logic sm0;
    logic sm1;
    logic mp_en;
    logic ren;
    logic tb8;
    logic rb8;
    logic ti;
    logic ri;
    logic fe;
    logic dbl;
    logic fe_sel;
    logic [7:0] rate;
    logic [7:0] rx_buf;
    spz_txst_t tx_st;
    logic [10:0] tx_sh;
    logic [15:0] tx_cnt;
    logic [3:0] tx_bits;
    spz_rxst_t rx_st;
    logic [8:0] rx_sh;
    logic [15:0] rx_cnt;
    logic [3:0] rx_bits;
    logic rxd_q;
    logic [2:0] irq_stat;
    logic [2:0] irq_mask;
    logic txd;
    logic rxo;
    logic rxoe;
    logic irq;
    logic req;
  } spz_state_t;

endpackage

// [logic/spz_serial_port.sv]
// serial port zero with axi4-lite register access
`timescale 1ns/1ps
`include "spz_regs.svh"

// Notes on behaviour
// - mode bits 00 shift mode, 01 ten-bit async, 10 eleven-bit fixed, 11 eleven-bit variable.
// - control bit 7 is the high mode bit or the framing error flag, per frame_error_select.
// - as framing error flag, bit 7 sets on a bad stop bit and holds until software clears it.
// - in eleven-bit modes with filtering on, a ninth bit of 0 raises no receive flag.
// - in ten-bit mode with filtering on, no receive flag without a valid stop bit.
// - in shift mode the filtering bit picks divide by 4 when set, by 12 when clear.
// - data is received only while the receive-enable bit is 1.
// - in eleven-bit modes tx_ninth_bit is sent as the ninth data bit.
// - rx_ninth_bit holds the ninth bit, or the stop bit in ten-bit mode with filtering off.
// - transmit flag sets after bit 8 in shift mode, else at stop bit start; software clears it.
// - receive flag sets after bit 8 in shift mode, else mid stop bit; software clears it.
// - baud_doubler doubles the bit rate in the ten-bit and eleven-bit modes.
// - the buffer address reads the receive buffer and writes the transmit buffer.
module spz_serial_port
  import spz_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [11:0] s_axi_awaddr_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  output logic [1:0] s_axi_bresp_out,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  input wire logic [11:0] s_axi_araddr_in,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic txd_out,
  input wire logic rxd_in,
  output logic rxd_out,
  output logic rxd_oe_out,
  output logic irq_out,
  output logic ser_req_out
);

  spz_state_t st_r;
  spz_state_t st_nxt;

  // clocks per bit for the selected mode
  function automatic logic [15:0] bit_len(input logic [1:0] mode,
                                          input logic mp,
                                          input logic dbl,
                                          input logic [7:0] rate);
    case (mode)
      2'b00: bit_len = mp ? `SPZ_M0_FAST_DIV : `SPZ_M0_SLOW_DIV;
      2'b10: bit_len = dbl ? `SPZ_M2_FAST_DIV : `SPZ_M2_SLOW_DIV;
      default: bit_len = ({8'h00, rate} + 16'h0001) *
                         (dbl ? `SPZ_OVS_DBL : `SPZ_OVS_NORM);
    endcase
  endfunction

  // word index of a byte address
  function automatic logic [9:0] reg_idx(input logic [11:0] addr);
    reg_idx = addr[11:2];
  endfunction

  // true for a mapped register
  function automatic logic reg_hit(input logic [11:0] addr);
    case (reg_idx(addr))
      `SPZ_IDX_SER_CTRL, `SPZ_IDX_SER_BUF, `SPZ_IDX_PWR_CTRL,
      `SPZ_IDX_IRQ_STAT, `SPZ_IDX_IRQ_MASK, `SPZ_IDX_RATE: reg_hit = 1'b1;
      default: reg_hit = 1'b0;
    endcase
  endfunction

  // next-state logic for the whole block
  always_comb begin
    logic [1:0] mode;
    logic [15:0] blen;
    logic [15:0] half;
    logic ti_set;
    logic ri_set;
    logic fe_set;
    logic [3:0] nbits;
    logic [8:0] nsh;
    logic ninth;
    logic [7:0] wd;
    logic [7:0] sc_rd;
    mode = 2'b00;
    blen = 16'h0000;
    half = 16'h0000;
    ti_set = 1'b0;
    ri_set = 1'b0;
    fe_set = 1'b0;
    nbits = 4'h0;
    nsh = 9'h000;
    ninth = 1'b0;
    wd = 8'h00;
    sc_rd = 8'h00;
    st_nxt = st_r;
    mode = {st_r.sm0, st_r.sm1};
    blen = bit_len(mode, st_r.mp_en, st_r.dbl, st_r.rate);
    half = blen >> 1;
    nbits = (mode == 2'b01) ? 4'd10 : 4'd11;
    st_nxt.rxd_q = rxd_in;

    // transmitter: one shift per bit period
    if (st_r.tx_st == SPZ_TX_RUN) begin
      if (st_r.tx_cnt >= blen - 16'h0001) begin
        st_nxt.tx_cnt = 16'h0000;
        st_nxt.tx_sh = {1'b1, st_r.tx_sh[10:1]};
        st_nxt.tx_bits = st_r.tx_bits + 4'd1;
        if (mode == 2'b00) begin
          if (st_r.tx_bits == 4'd7) begin
            ti_set = 1'b1;
            st_nxt.tx_st = SPZ_TX_IDLE;
          end
        end else begin
          if (st_r.tx_bits + 4'd1 == nbits - 4'd1) begin
            ti_set = 1'b1;
          end
          if (st_r.tx_bits + 4'd1 == nbits) begin
            st_nxt.tx_st = SPZ_TX_IDLE;
          end
        end
      end else begin
        st_nxt.tx_cnt = st_r.tx_cnt + 16'h0001;
      end
    end

    // receiver; dropping the enable abandons any frame under way
    case (st_r.rx_st)
      SPZ_RX_IDLE: begin
        st_nxt.rx_cnt = 16'h0000;
        st_nxt.rx_bits = 4'h0;
        if (st_r.ren) begin
          if (mode == 2'b00) begin
            // shift mode receive waits for a free flag and idle transmitter
            if (!st_r.ri && st_r.tx_st == SPZ_TX_IDLE) begin
              st_nxt.rx_st = SPZ_RX_SYNC;
            end
          end else if (st_r.rxd_q && !rxd_in) begin
            st_nxt.rx_st = SPZ_RX_START;
          end
        end
      end
      SPZ_RX_START: begin
        if (st_r.rx_cnt >= half - 16'h0001) begin
          st_nxt.rx_cnt = 16'h0000;
          // a glitch shorter than half a bit is not a start bit
          st_nxt.rx_st = rxd_in ? SPZ_RX_IDLE : SPZ_RX_DATA;
        end else begin
          st_nxt.rx_cnt = st_r.rx_cnt + 16'h0001;
        end
      end
      SPZ_RX_DATA: begin
        if (st_r.rx_cnt >= blen - 16'h0001) begin
          st_nxt.rx_cnt = 16'h0000;
          if (st_r.rx_bits == nbits - 4'd2) begin
            // mid stop bit: decide flag, ninth bit and framing error
            ninth = (mode == 2'b01) ? rxd_in : st_r.rx_sh[8];
            fe_set = !rxd_in;
            st_nxt.rx_st = SPZ_RX_IDLE;
            if (!st_r.ri &&
                (!st_r.mp_en || ninth)) begin
              st_nxt.rx_buf = (mode == 2'b01) ? st_r.rx_sh[8:1] :
                                                st_r.rx_sh[7:0];
              st_nxt.rb8 = ninth;
              ri_set = 1'b1;
            end
          end else begin
            st_nxt.rx_sh = {rxd_in, st_r.rx_sh[8:1]};
            st_nxt.rx_bits = st_r.rx_bits + 4'd1;
          end
        end else begin
          st_nxt.rx_cnt = st_r.rx_cnt + 16'h0001;
        end
      end
      SPZ_RX_SYNC: begin
        if (st_r.rx_cnt >= blen - 16'h0001) begin
          st_nxt.rx_cnt = 16'h0000;
          nsh = {rxd_in, st_r.rx_sh[8:1]};
          st_nxt.rx_sh = nsh;
          st_nxt.rx_bits = st_r.rx_bits + 4'd1;
          if (st_r.rx_bits == 4'd7) begin
            st_nxt.rx_buf = nsh[8:1];
            ri_set = 1'b1;
            st_nxt.rx_st = SPZ_RX_IDLE;
          end
        end else begin
          st_nxt.rx_cnt = st_r.rx_cnt + 16'h0001;
        end
      end
      default: st_nxt.rx_st = SPZ_RX_IDLE;
    endcase
    if (!st_r.ren) begin
      st_nxt.rx_st = SPZ_RX_IDLE;
    end

    // axi write channel capture
    if (s_axi_awvalid_in && !st_r.aw_v) begin
      st_nxt.aw_v = 1'b1;
      st_nxt.aw_addr = s_axi_awaddr_in;
    end
    if (s_axi_wvalid_in && !st_r.w_v) begin
      st_nxt.w_v = 1'b1;
      st_nxt.w_data = s_axi_wdata_in[7:0];
      st_nxt.w_lane0 = s_axi_wstrb_in[0];
    end
    if (st_r.b_v && s_axi_bready_in) begin
      st_nxt.b_v = 1'b0;
    end

    // register write once address and data are both held
    wd = st_r.w_data;
    if (st_r.aw_v && st_r.w_v && !st_r.b_v) begin
      st_nxt.aw_v = 1'b0;
      st_nxt.w_v = 1'b0;
      st_nxt.b_v = 1'b1;
      st_nxt.b_resp = reg_hit(st_r.aw_addr) ? `SPZ_RESP_OKAY :
                                              `SPZ_RESP_SLVERR;
      if (st_r.w_lane0) begin
        case (reg_idx(st_r.aw_addr))
          `SPZ_IDX_SER_CTRL: begin
            if (st_r.fe_sel) begin
              st_nxt.fe = wd[`SPZ_SC_MODE_HI] & st_r.fe;
            end else begin
              st_nxt.sm0 = wd[`SPZ_SC_MODE_HI];
            end
            st_nxt.sm1 = wd[`SPZ_SC_MODE_LO];
            st_nxt.mp_en = wd[`SPZ_SC_MP_EN];
            st_nxt.ren = wd[`SPZ_SC_RX_EN];
            st_nxt.tb8 = wd[`SPZ_SC_TX9];
            st_nxt.rb8 = wd[`SPZ_SC_RX9];
            st_nxt.ti = wd[`SPZ_SC_TX_DONE];
            st_nxt.ri = wd[`SPZ_SC_RX_DONE];
          end
          `SPZ_IDX_SER_BUF: begin
            // a new write restarts the transmitter even mid frame
            st_nxt.tx_st = SPZ_TX_RUN;
            st_nxt.tx_cnt = 16'h0000;
            st_nxt.tx_bits = 4'h0;
            if (mode == 2'b00) begin
              st_nxt.tx_sh = {3'b111, wd};
            end else begin
              st_nxt.tx_sh = {1'b1, (mode == 2'b01) ? 1'b1 : st_r.tb8,
                              wd, 1'b0};
            end
          end
          `SPZ_IDX_PWR_CTRL: begin
            st_nxt.dbl = wd[`SPZ_PC_BAUD_DBL];
            st_nxt.fe_sel = wd[`SPZ_PC_FE_SEL];
          end
          `SPZ_IDX_IRQ_STAT: st_nxt.irq_stat = st_r.irq_stat & ~wd[2:0];
          `SPZ_IDX_IRQ_MASK: st_nxt.irq_mask = wd[2:0];
          `SPZ_IDX_RATE: st_nxt.rate = wd;
          default: st_nxt.b_resp = `SPZ_RESP_SLVERR;
        endcase
      end
    end

    // hardware sets win over a software clear in the same cycle
    if (ti_set) begin
      st_nxt.ti = 1'b1;
      st_nxt.irq_stat[`SPZ_IRQ_TX] = 1'b1;
    end
    if (ri_set) begin
      st_nxt.ri = 1'b1;
      st_nxt.irq_stat[`SPZ_IRQ_RX] = 1'b1;
    end
    if (fe_set) begin
      st_nxt.fe = 1'b1;
      st_nxt.irq_stat[`SPZ_IRQ_FE] = 1'b1;
    end

    // axi read, answered one cycle after the address is taken
    sc_rd = {st_r.fe_sel ? st_r.fe : st_r.sm0, st_r.sm1, st_r.mp_en,
             st_r.ren, st_r.tb8, st_r.rb8, st_r.ti, st_r.ri};
    if (st_r.r_v && s_axi_rready_in) begin
      st_nxt.r_v = 1'b0;
    end
    if (s_axi_arvalid_in && !st_r.r_v) begin
      st_nxt.r_v = 1'b1;
      st_nxt.r_resp = reg_hit(s_axi_araddr_in) ? `SPZ_RESP_OKAY :
                                                 `SPZ_RESP_SLVERR;
      case (reg_idx(s_axi_araddr_in))
        `SPZ_IDX_SER_CTRL: st_nxt.r_data = {24'h000000, sc_rd};
        `SPZ_IDX_SER_BUF: st_nxt.r_data = {24'h000000, st_r.rx_buf};
        `SPZ_IDX_PWR_CTRL: st_nxt.r_data = {24'h000000, st_r.dbl,
                                            st_r.fe_sel, 6'h00};
        `SPZ_IDX_IRQ_STAT: st_nxt.r_data = {29'h00000000, st_r.irq_stat};
        `SPZ_IDX_IRQ_MASK: st_nxt.r_data = {29'h00000000, st_r.irq_mask};
        `SPZ_IDX_RATE: st_nxt.r_data = {24'h000000, st_r.rate};
        default: st_nxt.r_data = 32'h00000000;
      endcase
    end

    // pins: shift mode drives a clock on txd and data on the rxd pin
    st_nxt.txd = 1'b1;
    st_nxt.rxo = 1'b1;
    st_nxt.rxoe = 1'b0;
    if (st_nxt.tx_st == SPZ_TX_RUN) begin
      if (mode == 2'b00) begin
        st_nxt.txd = (st_nxt.tx_cnt >= (blen >> 1));
        st_nxt.rxo = st_nxt.tx_sh[0];
        st_nxt.rxoe = 1'b1;
      end else begin
        st_nxt.txd = st_nxt.tx_sh[0];
      end
    end else if (st_nxt.rx_st == SPZ_RX_SYNC) begin
      st_nxt.txd = (st_nxt.rx_cnt >= (blen >> 1));
    end
    st_nxt.irq = |(st_nxt.irq_stat & st_nxt.irq_mask);
    st_nxt.req = st_nxt.ti | st_nxt.ri;
  end

  // state register; line idles high
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      st_r <= '0;
      st_r.txd <= 1'b1;
      st_r.rxo <= 1'b1;
      st_r.rxd_q <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  // outputs
  assign s_axi_awready_out = !st_r.aw_v;
  assign s_axi_wready_out = !st_r.w_v;
  assign s_axi_bvalid_out = st_r.b_v;
  assign s_axi_bresp_out = st_r.b_resp;
  assign s_axi_arready_out = !st_r.r_v;
  assign s_axi_rvalid_out = st_r.r_v;
  assign s_axi_rdata_out = st_r.r_data;
  assign s_axi_rresp_out = st_r.r_resp;
  assign txd_out = st_r.txd;
  assign rxd_out = st_r.rxo;
  assign rxd_oe_out = st_r.rxoe;
  assign irq_out = st_r.irq;
  assign ser_req_out = st_r.req;

endmodule // spz_serial_port

// [bench/spz_chk_properties.sv]
// port-level checker for the serial port zero block
`timescale 1ns/1ps
module spz_chk (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic s_axi_awvalid_in,
  input wire logic s_axi_awready_out,
  input wire logic s_axi_wvalid_in,
  input wire logic s_axi_wready_out,
  input wire logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic [1:0] s_axi_bresp_out,
  input wire logic s_axi_arvalid_in,
  input wire logic s_axi_arready_out,
  input wire logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  input wire logic [31:0] s_axi_rdata_out,
  input wire logic txd_out,
  input wire logic rxd_oe_out,
  input wire logic irq_out,
  input wire logic ser_req_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  logic [3:0] since_w_r;
  // cycles since the last write beat, saturating
  always_ff @(posedge clk_in) begin
    if (rst_in || (s_axi_wvalid_in && s_axi_wready_out))
      since_w_r <= 4'h0;
    else if (since_w_r != 4'hf)
      since_w_r <= since_w_r + 4'h1;
  end
  property p_rst;
    $fell(rst_in) |-> txd_out && !irq_out && !ser_req_out;
  endproperty
  a_rst: assert property (p_rst)
    else $error("outputs not idle after reset");
  property p_b_hold;
    s_axi_bvalid_out && !s_axi_bready_in |=>
      s_axi_bvalid_out && $stable(s_axi_bresp_out);
  endproperty
  a_b_hold: assert property (p_b_hold)
    else $error("write answer dropped");
  property p_r_hold;
    s_axi_rvalid_out && !s_axi_rready_in |=>
      s_axi_rvalid_out && $stable(s_axi_rdata_out);
  endproperty
  a_r_hold: assert property (p_r_hold)
    else $error("read answer dropped");
  property p_r_lat;
    s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out;
  endproperty
  a_r_lat: assert property (p_r_lat)
    else $error("read answer late");
  property p_r_busy;
    s_axi_rvalid_out |-> !s_axi_arready_out;
  endproperty
  a_r_busy: assert property (p_r_busy)
    else $error("read address taken while busy");
  property p_r_byte;
    s_axi_rvalid_out |-> s_axi_rdata_out[31:8] == 24'h0;
  endproperty
  a_r_byte: assert property (p_r_byte)
    else $error("upper read bits not zero");
  property p_w_lat;
    s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in &&
      s_axi_wready_out && !s_axi_bvalid_out |-> ##[1:3] s_axi_bvalid_out;
  endproperty
  a_w_lat: assert property (p_w_lat)
    else $error("write answer late");
  property p_start;
    $fell(txd_out) && !rxd_oe_out |=> !txd_out;
  endproperty
  a_start: assert property (p_start)
    else $error("low line level too short");
  property p_req_sw;
    $fell(ser_req_out) |-> since_w_r <= 4'h4;
  endproperty
  a_req_sw: assert property (p_req_sw)
    else $error("flag cleared without a write");
  c_irq: cover property ($rose(irq_out));
  c_req: cover property ($rose(ser_req_out));
  c_shift: cover property ($rose(rxd_oe_out));
endmodule // spz_chk

bind spz_serial_port spz_chk u_chk (.clk_in, .rst_in,
  .s_axi_awvalid_in, .s_axi_awready_out, .s_axi_wvalid_in,
  .s_axi_wready_out, .s_axi_bvalid_out, .s_axi_bready_in,
  .s_axi_bresp_out, .s_axi_arvalid_in, .s_axi_arready_out,
  .s_axi_rvalid_out, .s_axi_rready_in, .s_axi_rdata_out, .txd_out,
  .rxd_oe_out, .irq_out, .ser_req_out);

// [bench/spz_peer.sv]
// remote serial peer: drives the receive line, captures frames
`timescale 1ns/1ps
module spz_peer (
  input wire logic clk_in,
  input wire logic txd_in,
  input wire logic dat_in,
  input wire logic oe_in,
  output logic line_out
);
  initial line_out = 1'b1; // line idles at mark
  // send n bits lsb first, b clocks each, then back to mark
  task automatic send(input logic [10:0] v, input int n, input int b);
    for (int i = 0; i < n; i++) begin
      line_out <= v[i];
      repeat (b) @(posedge clk_in);
    end
    line_out <= 1'b1;
  endtask
  // sample mid-bit so a cycle of skew either way is tolerated
  task automatic grab(input int n, input int b, output logic [10:0] v,
                      output logic ok);
    int k;
    v = '0;
    ok = 1'b0;
    k = 0;
    while (txd_in && k < 2000) begin
      @(posedge clk_in);
      k++;
    end
    if (k >= 2000) return;
    repeat (b / 2) @(posedge clk_in);
    for (int i = 0; i < n; i++) begin
      v[i] = txd_in;
      if (i < n - 1) repeat (b) @(posedge clk_in);
    end
    ok = 1'b1;
  endtask
  // shift mode: data taken at each rising shift clock while driven
  task automatic grab0(output logic [7:0] v, output int per);
    int k, i, t0;
    logic p;
    k = 0;
    i = 0;
    t0 = 0;
    per = 0;
    v = '0;
    p = 1'b1;
    while (i < 8 && k < 400) begin
      @(posedge clk_in);
      k++;
      if (!p && txd_in && oe_in) begin
        v[i] = dat_in;
        if (i == 1) per = k - t0;
        t0 = k;
        i++;
      end
      p = txd_in;
    end
  endtask
endmodule // spz_peer

// [bench/testbench.sv]
// self-checking bench for serial port zero
`timescale 1ns/1ps
`include "spz_regs.svh"
module testbench;
  logic clk_in, rst_in, rxd_in, txd_out, rxd_out, rxd_oe_out;
  logic irq_out, ser_req_out;
  logic s_axi_awvalid_in, s_axi_awready_out, s_axi_wvalid_in;
  logic s_axi_wready_out, s_axi_bvalid_out, s_axi_bready_in;
  logic s_axi_arvalid_in, s_axi_arready_out, s_axi_rvalid_out;
  logic s_axi_rready_in;
  logic [11:0] s_axi_awaddr_in, s_axi_araddr_in;
  logic [31:0] s_axi_wdata_in, s_axi_rdata_out, d;
  logic [3:0] s_axi_wstrb_in;
  logic [1:0] s_axi_bresp_out, s_axi_rresp_out;
  logic [10:0] v;
  logic [7:0] b8, g8;
  logic ok, t9;
  int n_errors, n_checks, seed, per, bt, n;
  localparam logic [11:0] ad_sc = {`SPZ_IDX_SER_CTRL, 2'b00};
  localparam logic [11:0] ad_sb = {`SPZ_IDX_SER_BUF, 2'b00};
  localparam logic [11:0] ad_pc = {`SPZ_IDX_PWR_CTRL, 2'b00};
  localparam logic [11:0] ad_st = {`SPZ_IDX_IRQ_STAT, 2'b00};
  localparam logic [11:0] ad_mk = {`SPZ_IDX_IRQ_MASK, 2'b00};
  localparam logic [11:0] ad_rt = {`SPZ_IDX_RATE, 2'b00};
  logic [1:0] md [5] = '{2'd1, 2'd2, 2'd2, 2'd3, 2'd3};
  logic [7:0] rc [5] = '{8'hf0, 8'hf0, 8'h50, 8'h70, 8'h40};
  logic [4:0] rx9 = 5'b10110;
  logic [4:0] fes = 5'b01000;
  // receive model: bytes that must land in the buffer, oldest first
  logic [7:0] exp_q [$];
  logic ex;

  spz_serial_port DUT (.clk_in, .rst_in, .s_axi_awvalid_in,
    .s_axi_awready_out, .s_axi_awaddr_in, .s_axi_wvalid_in,
    .s_axi_wready_out, .s_axi_wdata_in, .s_axi_wstrb_in,
    .s_axi_bvalid_out, .s_axi_bready_in, .s_axi_bresp_out,
    .s_axi_arvalid_in, .s_axi_arready_out, .s_axi_araddr_in,
    .s_axi_rvalid_out, .s_axi_rready_in, .s_axi_rdata_out,
    .s_axi_rresp_out, .txd_out, .rxd_in, .rxd_out, .rxd_oe_out,
    .irq_out, .ser_req_out);
  spz_peer u_peer (.clk_in, .txd_in(txd_out), .dat_in(rxd_out),
    .oe_in(rxd_oe_out), .line_out(rxd_in));

  // 100 MHz clock
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end

  task automatic end_sim;
    if (n_errors == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] s, e);
    n_checks++;
    if (s !== e) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask

  // one write; address and data offered together, each dropped when taken
  task automatic wr(input logic [11:0] a, input logic [7:0] w,
                    input logic [1:0] er = `SPZ_RESP_OKAY);
    int k;
    @(posedge clk_in);
    s_axi_awvalid_in <= 1'b1;
    s_axi_awaddr_in <= a;
    s_axi_wvalid_in <= 1'b1;
    s_axi_wdata_in <= {24'h0, w};
    s_axi_bready_in <= 1'b1;
    k = 0;
    do begin
      @(posedge clk_in);
      k++;
      if (s_axi_awready_out) s_axi_awvalid_in <= 1'b0;
      if (s_axi_wready_out) s_axi_wvalid_in <= 1'b0;
    end while (!s_axi_bvalid_out && k < 500);
    s_axi_bready_in <= 1'b0;
    if (k >= 500) begin
      n_errors++;
      end_sim();
    end
    chk("bresp", {30'h0, s_axi_bresp_out}, {30'h0, er});
  endtask

  // one read; rready held until the answer is sampled
  task automatic rd(input logic [11:0] a, output logic [31:0] r,
                    input logic [1:0] er = `SPZ_RESP_OKAY);
    int k;
    @(posedge clk_in);
    s_axi_arvalid_in <= 1'b1;
    s_axi_araddr_in <= a;
    s_axi_rready_in <= 1'b1;
    k = 0;
    do begin
      @(posedge clk_in);
      k++;
      if (s_axi_arready_out) s_axi_arvalid_in <= 1'b0;
    end while (!s_axi_rvalid_out && k < 500);
    s_axi_rready_in <= 1'b0;
    r = s_axi_rdata_out;
    if (k >= 500) begin
      n_errors++;
      end_sim();
    end
    chk("rresp", {30'h0, s_axi_rresp_out}, {30'h0, er});
  endtask

  // main sequence
  initial begin
    seed = 32'h47ca;
    rst_in = 1'b1;
    s_axi_awvalid_in = 1'b0;
    s_axi_wvalid_in = 1'b0;
    s_axi_bready_in = 1'b0;
    s_axi_arvalid_in = 1'b0;
    s_axi_rready_in = 1'b0;
    s_axi_awaddr_in = 12'h0;
    s_axi_araddr_in = 12'h0;
    s_axi_wdata_in = 32'h0;
    s_axi_wstrb_in = 4'h1;
    repeat (3) @(posedge clk_in);
    rst_in <= 1'b0;
    rd(ad_sc, d);
    chk("ctrl_rst", d, 32'h0);
    rd(12'h000, d, `SPZ_RESP_SLVERR);
    chk("unmapped", d, 32'h0);
    wr(12'h000, 8'h5a, `SPZ_RESP_SLVERR);
    // a write with lane 0 off must leave the register alone
    s_axi_wstrb_in <= 4'h0;
    wr(ad_mk, 8'h07);
    rd(ad_mk, d);
    chk("strb_off", d, 32'h0);
    s_axi_wstrb_in <= 4'h1;
    wr(ad_mk, 8'h07);
    rd(ad_mk, d);
    chk("mask", d, 32'h7);
    // async transmit: every async mode; rate doubler on and off in the eleven-bit modes, off only in ten-bit mode
    for (int i = 0; i < 5; i++) begin
      b8 = 8'($random(seed));
      t9 = 1'($random(seed));
      // first pass uses rate 1, so its bit is twice the base length
      bt = (md[i] == 2'd2) ? (i[0] ? 32 : 64) :
           ((i[0] ? 8 : 16) * ((i == 0) ? 2 : 1));
      n = (md[i] == 2'd1) ? 10 : 11;
      wr(ad_rt, {7'h0, i == 0});
      wr(ad_pc, {i[0], 7'h0});
      wr(ad_sc, {md[i], 2'b00, t9, 3'b000});
      fork
        u_peer.grab(n, bt, v, ok);
        wr(ad_sb, b8);
      join
      chk("frame", {20'h0, ok, v}, (n == 10) ? {20'h0, 3'b101, b8, 1'b0}
          : {20'h0, 2'b11, t9, b8, 1'b0});
      rd(ad_sc, d);
      chk("tx_done", d & 32'h2, 32'h2);
      chk("irq", {31'h0, irq_out}, 32'h1);
      chk("req", {31'h0, ser_req_out}, 32'h1);
      repeat (bt) @(posedge clk_in);
      wr(ad_sc, 8'h00);
      wr(ad_st, 8'h07);
      repeat (2) @(posedge clk_in);
      chk("irq_clr", {31'h0, irq_out}, 32'h0);
    end
    // receive: filtering, stop bit, framing error, disabled receiver
    for (int j = 0; j < 5; j++) begin
      b8 = 8'($random(seed));
      wr(ad_pc, {1'b0, fes[j], 6'h0});
      wr(ad_sc, rc[j]);
      // flag only when enabled and the ninth or stop bit passes the filter
      ex = rc[j][4] && (!rc[j][5] || rx9[j]);
      if (ex)
        exp_q.push_back(b8);
      u_peer.send({1'b1, rx9[j], b8, 1'b0}, rc[j][7] ? 11 : 10, 16);
      repeat (4) @(posedge clk_in);
      rd(ad_sc, d);
      chk("rx_done", d & 32'h1, {31'h0, ex});
      if (fes[j])
        chk("frame_err", d & 32'h80, 32'h80);
      if (ex) begin
        chk("rx9", d & 32'h4, {29'h0, rx9[j], 2'b00});
        rd(ad_sb, d);
        chk("rx_buf", d, {24'h0, exp_q.pop_front()});
      end
      wr(ad_sc, 8'h00);
      wr(ad_pc, 8'h00);
      wr(ad_st, 8'h07);
    end
    // shift mode at both rates, interrupt masked off
    wr(ad_mk, 8'h00);
    for (int j = 0; j < 2; j++) begin
      b8 = 8'($random(seed));
      wr(ad_sc, {2'b00, j[0], 5'h0});
      fork
        u_peer.grab0(g8, per);
        wr(ad_sb, b8);
      join
      chk("shift_data", {24'h0, g8}, {24'h0, b8});
      chk("shift_per", 32'(per), j ? 32'd4 : 32'd12);
      repeat (20) @(posedge clk_in);
      rd(ad_sc, d);
      chk("tx_done0", d & 32'h2, 32'h2);
      chk("irq_mask", {30'h0, irq_out, ser_req_out}, 32'h1);
      wr(ad_sc, 8'h00);
      wr(ad_st, 8'h07);
    end
    end_sim();
  end
endmodule // testbench
